// >>> logic/bit_port.sv
// Operation
// - raw mode puts demodulated subcarrier on serial output; host decodes it.
// - transmit mode only sends, receive mode only receives, same internal layer.
// - bit modes go through built-in coders, four modulation schemes only.
// - every bit in bit modes except the first transmit bit moves with a device-made bit clock.
// - receive mode puts each decoded bit on the serial output.
// - receive mode drives a bit clock with each decoded bit.
// - receive mode raises interrupt when the incoming frame ends.
// - while enable high and the buffer has room, device pulses bit clock asking for next bit.
// - framed mode uses built-in FIFO and serial bus for host traffic.
// - host changes data on rising edge, device latches on falling edge.
`timescale 1ns/1ps
`default_nettype none
module bit_port
  import bit_port_pkg::*;
#(
  parameter int HALF_CYCLES = BIT_HALF_CYC
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  // mode selects from the control logic
  input  wire logic       i_bit_level_transmit_mode,
  input  wire logic       i_bit_level_receive_mode,
  input  wire logic       i_raw_front_end_mode,
  input  wire logic [1:0] i_scheme,
  // host pins
  input  wire logic       i_tx_enable,
  input  wire logic       i_tx_data,
  input  wire logic       i_modulation_input_pin,
  output logic            o_bit_clock,
  output logic            o_serial_out,
  output logic            o_irq,
  // framed-mode serial data from the framing engine
  input  wire logic       i_framed_miso,
  // encoder side
  output logic            o_enc_valid,
  output logic            o_enc_bit,
  input  wire logic       i_enc_ready,
  output logic [1:0]      o_enc_scheme,
  output logic            o_enc_frame,
  // decoder side
  input  wire logic       i_dec_valid,
  input  wire logic       i_dec_bit,
  input  wire logic       i_dec_end,
  output logic            o_dec_ready,
  // analogue front end
  input  wire logic       i_raw_demod,
  output logic            o_front_end_mod
);
  localparam int CNT_W = $clog2(HALF_CYCLES + 1);

  typedef struct packed {
    logic [SYNC_LANES-1:0] sync1;
    logic [SYNC_LANES-1:0] sync2;
    logic [SYNC_LANES-1:0] sync3;
    logic [SYNC_LANES-1:0] filt;
    phase_t                phase;
    logic [CNT_W-1:0]      cnt;
    logic                  bit_clock;
    logic                  serial_out;
    logic                  mod_out;
    logic                  irq;
    logic                  end_pend;
    logic                  rx_bit;
    logic                  dec_ready;
    logic                  frame;
    logic                  push;
    logic                  push_bit;
    logic [1:0]            scheme;
  } port_state_t;

  port_state_t s;
  port_state_t next_s;
  port_mode_t  cur_mode;
  logic        en_f;
  logic        dat_f;
  logic        fifo_in_ready;
  logic        fifo_empty;
  logic        cnt_end;

  // raw mode wins, since it bypasses the coders entirely
  function automatic port_mode_t decode_mode(input logic raw, input logic tx, input logic rx);
    if (raw) begin
      return MODE_RAW;
    end else if (tx) begin
      return MODE_TX;
    end else if (rx) begin
      return MODE_RX;
    end
    return MODE_FRAMED;
  endfunction : decode_mode

  assign cur_mode = decode_mode(i_raw_front_end_mode, i_bit_level_transmit_mode,
                                i_bit_level_receive_mode);
  assign en_f     = s.filt[SYNC_TX_EN];
  assign dat_f    = s.filt[SYNC_TX_DAT];
  assign cnt_end  = (s.cnt == CNT_W'(HALF_CYCLES - 1));

  // latched transmit bits wait here until the encoder takes them
  bit_fifo #(
    .WIDTH (TX_FIFO_WIDTH),
    .DEPTH (TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk       (i_clk),
    .i_arst_n    (i_arst_n),
    .i_in_valid  (s.push),
    .i_in_data   (s.push_bit),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (o_enc_valid),
    .o_out_data  (o_enc_bit),
    .i_out_ready (i_enc_ready),
    .o_empty     (fifo_empty)
  );

  always_comb begin
    next_s        = s;
    next_s.sync1  = {i_raw_demod, i_modulation_input_pin, i_tx_data, i_tx_enable};
    next_s.sync2  = s.sync1;
    next_s.sync3  = s.sync2;
    // a pin change counts only once the last two stages agree
    next_s.filt   = (~(s.sync2 ^ s.sync3) & s.sync3) | ((s.sync2 ^ s.sync3) & s.filt);
    next_s.push   = 1'b0;
    next_s.mod_out = 1'b0;
    next_s.scheme = i_scheme;
    next_s.bit_clock = 1'b0;
    next_s.dec_ready = 1'b0;
    unique case (cur_mode)
      MODE_RAW: begin
        next_s.serial_out = s.filt[SYNC_DEMOD];
        next_s.mod_out    = s.filt[SYNC_MOD];
      end
      MODE_FRAMED: next_s.serial_out = i_framed_miso;
      MODE_TX:     next_s.serial_out = 1'b0;
      MODE_RX:     next_s.serial_out = s.rx_bit;
    endcase
    if (s.cnt != CNT_W'(HALF_CYCLES - 1)) begin
      next_s.cnt = s.cnt + 1'b1;
    end
    unique case (s.phase)
      PH_IDLE: begin
        if (cur_mode == MODE_TX && en_f && fifo_in_ready) begin
          // first bit was already on the pin when enable went high
          next_s.push     = 1'b1;
          next_s.push_bit = dat_f;
          next_s.frame    = 1'b1;
          next_s.phase    = PH_TX_LOW;
          next_s.cnt      = '0;
        end else if (cur_mode == MODE_RX && i_dec_valid && s.dec_ready) begin
          next_s.rx_bit     = i_dec_bit;
          next_s.serial_out = i_dec_bit;
          next_s.phase      = PH_RX_SETUP;
          next_s.cnt        = '0;
        end
      end
      PH_TX_LOW: begin
        if (cur_mode != MODE_TX || !en_f) begin
          next_s.phase = PH_IDLE;
        end else if (cnt_end && fifo_in_ready) begin
          // the rising edge asks the host for its next bit
          next_s.bit_clock = 1'b1;
          next_s.phase     = PH_TX_HIGH;
          next_s.cnt       = '0;
        end
      end
      PH_TX_HIGH: begin
        if (cur_mode != MODE_TX) begin
          next_s.phase = PH_IDLE;
        end else if (cnt_end) begin
          // a requested bit is latched even if enable dropped meanwhile
          next_s.push     = 1'b1;
          next_s.push_bit = dat_f;
          next_s.phase    = PH_TX_LOW;
          next_s.cnt      = '0;
        end else begin
          next_s.bit_clock = 1'b1;
        end
      end
      PH_RX_SETUP, PH_RX_HIGH, PH_RX_LOW: begin
        if (cur_mode != MODE_RX) begin
          next_s.phase = PH_IDLE;
        end else begin
          next_s.bit_clock = (s.phase == PH_RX_HIGH) ^ (s.phase == PH_RX_SETUP && cnt_end);
          if (s.phase == PH_RX_HIGH && cnt_end) begin
            next_s.bit_clock = 1'b0;
          end
          if (cnt_end) begin
            next_s.cnt   = '0;
            next_s.phase = (s.phase == PH_RX_SETUP) ? PH_RX_HIGH :
                           (s.phase == PH_RX_HIGH) ? PH_RX_LOW : PH_IDLE;
          end
        end
      end
      default: next_s.phase = PH_IDLE;
    endcase
    // frame stays open until every latched bit has left the buffer
    if (s.frame && s.phase == PH_IDLE && !en_f && fifo_empty && !s.push) begin
      next_s.frame = 1'b0;
    end
    if (cur_mode == MODE_RX) begin
      if (s.end_pend && s.phase == PH_IDLE) begin
        next_s.irq      = 1'b1;
        next_s.end_pend = 1'b0;
      end
      // a new frame end in the hand-off cycle stays pending
      if (i_dec_end) begin
        next_s.end_pend = 1'b1;
      end
      next_s.dec_ready = (next_s.phase == PH_IDLE) && !next_s.end_pend && !next_s.irq;
    end else begin
      // leaving receive mode is what acknowledges the interrupt
      next_s.irq      = 1'b0;
      next_s.end_pend = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s        <= '0;
      s.phase  <= PH_IDLE;
      s.scheme <= SCHEME_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign o_bit_clock     = s.bit_clock;
  assign o_serial_out    = s.serial_out;
  assign o_irq           = s.irq;
  assign o_front_end_mod = s.mod_out;
  assign o_enc_scheme    = s.scheme;
  assign o_enc_frame     = s.frame;
  assign o_dec_ready     = s.dec_ready;

  // helper: length of each high phase of the bit clock
  logic [CNT_W:0] hi_len;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hi_len <= '0;
    end else begin
      hi_len <= o_bit_clock ? hi_len + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence tx_en_low_seq;
    !en_f && cur_mode == MODE_TX && s.phase == PH_TX_LOW;
  endsequence
  sequence tx_fall_seq;
    $fell(o_bit_clock) && $past(s.phase == PH_TX_HIGH) && $past(cur_mode == MODE_TX);
  endsequence

  chk_raw_demod_out: assert property ((cur_mode == MODE_RAW) |=>
    (o_serial_out == $past(s.filt[SYNC_DEMOD]))) else $error("raw demod not on serial out");
  chk_clock_mode_only: assert property ((cur_mode == MODE_RAW || cur_mode == MODE_FRAMED)
    |=> !o_bit_clock) else $error("bit clock outside bit-level modes");
  chk_push_tx_only: assert property (s.push |-> $past(cur_mode == MODE_TX))
    else $error("bit buffered outside transmit mode");
  chk_rx_bit_out: assert property ((cur_mode == MODE_RX && i_dec_valid && o_dec_ready)
    |=> (o_serial_out == $past(i_dec_bit)) ##1 $stable(o_serial_out)) else $error("rx bit lost");
  chk_rx_clock_hold: assert property ((s.phase == PH_RX_HIGH && cur_mode == MODE_RX)
    |-> $stable(o_serial_out)) else $error("serial out moved under rx clock");
  chk_irq_rx_end: assert property ($rose(o_irq) |-> $past(cur_mode == MODE_RX))
    else $error("interrupt outside receive mode");
  chk_tx_rise_en: assert property (($rose(o_bit_clock) && $past(cur_mode == MODE_TX))
    |-> $past(en_f)) else $error("tx pulse without enable");
  chk_tx_fall_latch: assert property (tx_fall_seq |-> s.push && s.push_bit == $past(dat_f))
    else $error("data not latched on falling edge");
  chk_stop_pulses: assert property (tx_en_low_seq |=> !o_bit_clock && s.phase == PH_IDLE)
    else $error("pulse after enable low");
  chk_frame_drain: assert property ($fell(o_enc_frame) |-> $past(fifo_empty))
    else $error("frame closed with bits pending");
  chk_half_period: assert property ($fell(o_bit_clock) && $past(cur_mode) == $past(cur_mode, 2)
    |-> hi_len == (CNT_W + 1)'(HALF_CYCLES)) else $error("bad pulse width");
  chk_framed_miso: assert property ((cur_mode == MODE_FRAMED) |=>
    (o_serial_out == $past(i_framed_miso))) else $error("framed data not passed");

endmodule : bit_port
`default_nettype wire

// >>> common/bit_port_pkg.sv
package bit_port_pkg;

  // port modes, decoded from the mode selects
  typedef enum logic [1:0] {
    MODE_FRAMED,
    MODE_TX,
    MODE_RX,
    MODE_RAW
  } port_mode_t;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_TX_LOW,
    PH_TX_HIGH,
    PH_RX_SETUP,
    PH_RX_HIGH,
    PH_RX_LOW
  } phase_t;

  // timing: bit clock half period, about 106 kbit/s
  localparam int CLK_PERIOD_NS = 5;
  localparam int BIT_HALF_NS   = 4720;
  localparam int BIT_HALF_CYC  = (BIT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // transmit bit buffer
  localparam int TX_FIFO_WIDTH = 1;
  localparam int TX_FIFO_DEPTH = 32;

  // pin synchroniser lanes
  localparam int SYNC_LANES  = 4;
  localparam int SYNC_TX_EN  = 0;
  localparam int SYNC_TX_DAT = 1;
  localparam int SYNC_MOD    = 2;
  localparam int SYNC_DEMOD  = 3;

  localparam logic [1:0] SCHEME_RESET = 2'h0;

endpackage : bit_port_pkg

// >>> logic/bit_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  // filling side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // draining side
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready,
  // nothing stored and nothing presented
  output logic                  o_empty
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0]  wr;
    logic [AW-1:0]  rd;
    logic [AW:0]    count;
    logic           out_valid;
    logic [WIDTH-1:0] out_data;
  } fifo_state_t;

  fifo_state_t      s;
  fifo_state_t      next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             load;

  assign o_in_ready  = (s.count != (AW+1)'(DEPTH));
  assign o_out_valid = s.out_valid;
  assign o_out_data  = s.out_data;
  assign o_empty     = (s.count == '0) && !s.out_valid;

  always_comb begin
    next_s = s;
    push   = i_in_valid && o_in_ready;
    // the output register refills as soon as it is free or being taken
    load   = (s.count != '0) && (!s.out_valid || i_out_ready);
    if (load) begin
      next_s.out_data  = mem[s.rd];
      next_s.out_valid = 1'b1;
      next_s.rd        = (s.rd == AW'(DEPTH - 1)) ? '0 : AW'(s.rd + 1'b1);
    end else if (i_out_ready) begin
      next_s.out_valid = 1'b0;
    end
    if (push) begin
      next_s.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : AW'(s.wr + 1'b1);
    end
    unique case ({push, load})
      2'b10:   next_s.count = s.count + 1'b1;
      2'b01:   next_s.count = s.count - 1'b1;
      default: next_s.count = s.count;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[s.wr] <= i_in_data;
    end
  end

endmodule : bit_fifo
`default_nettype wire

// >>> tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // host clock
  input  wire logic i_link_clk,
  // device pins
  input  wire logic i_bit_clock,
  output logic      o_tx_enable,
  output logic      o_tx_data,
  output logic      o_mod
);
  logic seen;

  initial begin
    o_tx_enable = 1'b0;
    o_tx_data   = 1'b0;
    o_mod       = 1'b0;
  end

  // frame bits arrive lsb first with parity and crc already in place
  task automatic send(input logic [63:0] bits, input int n);
    int k;
    @(posedge i_link_clk);
    #1 o_tx_data = bits[0];
    @(posedge i_link_clk);
    #1 o_tx_enable = 1'b1;
    for (k = 1; k < n; k++) begin
      seen = i_bit_clock;
      forever begin
        @(posedge i_link_clk);
        if (i_bit_clock && !seen) break;
        seen = i_bit_clock;
      end
      #1 o_tx_data = bits[k];
    end
    o_tx_enable = 1'b0;
    // line is left floating; flip it only once the last pulse is surely over
    repeat (4) @(posedge i_link_clk);
    #1 o_tx_data = ~bits[n-1];
  endtask : send

  // raw mode: the host times the modulation itself
  task automatic drive_mod(input logic v);
    @(posedge i_link_clk);
    #1 o_mod = v;
  endtask : drive_mod
endmodule : host_model
`default_nettype wire

// >>> tb/bit_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bit_port_bench;
  import bit_port_pkg::*;
  // high phase must outlast host clock plus pin sync
  localparam int HALF = 24;
  logic       i_clk, i_arst_n, link_clk, tx_mode, rx_mode, raw_mode, miso, enc_ready;
  logic       dec_valid, dec_bit, dec_end, raw_demod, bc_q, sent;
  logic [1:0] scheme;
  wire        tx_en, tx_dat, modulation_input_pin, bit_clock, serial_out, irq, enc_valid, enc_bit;
  wire        enc_frame, dec_ready, fe_mod;
  wire  [1:0] enc_scheme;
  int         err_count, checks_done, cycles, pulses, hi_len;
  logic       got[$];

  bit_port #(.HALF_CYCLES(HALF)) i_bit_port (
    .i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_bit_level_transmit_mode(tx_mode), .i_bit_level_receive_mode(rx_mode),
    .i_raw_front_end_mode(raw_mode), .i_scheme(scheme),
    .i_tx_enable(tx_en), .i_tx_data(tx_dat), .i_modulation_input_pin(modulation_input_pin),
    .o_bit_clock(bit_clock), .o_serial_out(serial_out), .o_irq(irq),
    .i_framed_miso(miso), .o_enc_valid(enc_valid), .o_enc_bit(enc_bit),
    .i_enc_ready(enc_ready), .o_enc_scheme(enc_scheme), .o_enc_frame(enc_frame),
    .i_dec_valid(dec_valid), .i_dec_bit(dec_bit), .i_dec_end(dec_end),
    .o_dec_ready(dec_ready), .i_raw_demod(raw_demod), .o_front_end_mod(fe_mod));

  host_model i_host_model (
    .i_link_clk(link_clk), .i_bit_clock(bit_clock),
    .o_tx_enable(tx_en), .o_tx_data(tx_dat), .o_mod(modulation_input_pin));

  always #2.5 i_clk = ~i_clk;
  // the host keeps its own timing from this free-running clock
  always #24 link_clk = ~link_clk;

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results;
    if (err_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step

  // settled values are looked at on the falling clock edge
  always @(negedge i_clk) begin
    cycles++;
    if (cycles > 20000) begin
      err_count++;
      results();
    end
    if (bit_clock && !bc_q) pulses++;
    if (bit_clock) hi_len++;
    if (bc_q && !bit_clock) begin
      check("bit clock high cycles", 8'(HALF), 8'(hi_len));
      hi_len = 0;
    end
    if (enc_valid && enc_ready) got.push_back(enc_bit);
    bc_q = bit_clock;
  end

  // more bits than the buffer holds while the encoder stalls, then drain
  task automatic tx_fill_drain;
    logic [63:0] pat;
    int          k;
    pat = 64'h0000_00C3_5A96_F01E;
    // the mode select stands in for the host's mode-entry write sequence
    tx_mode = 1'b1;
    step(4);
    got.delete();
    pulses = 0;
    sent = 1'b0;
    fork
      begin
        i_host_model.send(pat, 40);
        sent = 1'b1;
      end
    join_none
    step(36 * 2 * HALF);
    // buffer words plus the output register hold one more bit than pulses
    check("stalled pulses", 8'(TX_FIFO_DEPTH), 8'(pulses));
    check("nothing taken while stalled", 8'h00, 8'(got.size()));
    check("frame during stall", 8'h01, {7'h00, enc_frame});
    check("serial out in tx", 8'h00, {7'h00, serial_out});
    enc_ready = 1'b1;
    for (k = 0; k < 6000 && !sent; k++) step(1);
    step(300);
    check("tx pulses", 8'd39, 8'(pulses));
    check("tx bits encoded", 8'd40, 8'(got.size()));
    for (k = 0; k < 40 && k < got.size(); k++) check("tx bit", {7'h00, pat[k]}, {7'h00, got[k]});
    check("frame after drain", 8'h00, {7'h00, enc_frame});
    tx_mode = 1'b0;
  endtask : tx_fill_drain

  task automatic rx_bits;
    logic [3:0] pat;
    int         k;
    int         w;
    pat = 4'b1101;
    rx_mode = 1'b1;
    for (k = 0; k < 5; k++) begin
      for (w = 0; w < 200 && dec_ready !== 1'b1; w++) step(1);
      dec_valid = (k < 4);
      dec_end = (k == 4);
      dec_bit = pat[k % 4];
      step(1);
      dec_valid = 1'b0;
      dec_end = 1'b0;
      dec_bit = ~pat[k % 4];
      check("dec ready after take", 8'h00, {7'h00, dec_ready});
      for (w = 0; w < 200 && k < 4 && bit_clock !== 1'b1; w++) step(1);
      if (k < 4) check("rx bit", {7'h00, pat[k]}, {7'h00, serial_out});
    end
    for (w = 0; w < 50 && irq !== 1'b1; w++) step(1);
    check("irq at frame end", 8'h01, {7'h00, irq});
    rx_mode = 1'b0;
    step(3);
    check("irq after leaving rx", 8'h00, {7'h00, irq});
  endtask : rx_bits

  task automatic raw_framed_scheme;
    int k;
    int p0;
    raw_mode = 1'b1;
    p0 = pulses;
    for (k = 0; k < 2; k++) begin
      i_host_model.drive_mod(~k[0]);
      raw_demod = k[0];
      step(12);
      check("front end mod", {7'h00, ~k[0]}, {7'h00, fe_mod});
      check("raw serial out", {7'h00, k[0]}, {7'h00, serial_out});
    end
    check("raw bit clock pulses", 8'(p0), 8'(pulses));
    raw_mode = 1'b0;
    for (k = 0; k < 4; k++) begin
      miso = k[0];
      scheme = k[1:0];
      step(3);
      check("framed serial out", {7'h00, k[0]}, {7'h00, serial_out});
      check("scheme", {6'h00, k[1:0]}, {6'h00, enc_scheme});
    end
  endtask : raw_framed_scheme

  initial begin
    {i_clk, link_clk, i_arst_n, tx_mode, rx_mode, raw_mode, miso} = '0;
    {enc_ready, dec_valid, dec_bit, dec_end, raw_demod, bc_q} = '0;
    scheme = 2'h0;
    sent = 1'b0;
    repeat (12) @(posedge i_clk);
    #1 i_arst_n = 1'b1;
    step(6);
    // the block leaves reset in framed mode and is then switched to transmit
    tx_fill_drain();
    rx_bits();
    raw_framed_scheme();
    results();
  end
endmodule : bit_port_bench
`default_nettype wire
